// ===== shared/cmpc_pkg.sv
// constants and register map of the comparator control block
package cmpc_pkg;
    // ==================== register offsets
    localparam logic [11:0] ctrl_a_off0   = 12'h000;
    localparam logic [11:0] ctrl_b_off0   = 12'h004;
    localparam logic [11:0] ctrl_a_off1   = 12'h008;
    localparam logic [11:0] ctrl_b_off1   = 12'h00C;
    localparam logic [11:0] result_off    = 12'h010;
    localparam logic [11:0] irq_flag_off  = 12'h014;
    localparam logic [11:0] irq_en_off    = 12'h018;
    localparam logic [11:0] irq_ctl_off   = 12'h01C;
    localparam logic [11:0] analog_sel_off = 12'h020;
    localparam logic [11:0] pindir_off    = 12'h024;
    localparam logic [11:0] port_off      = 12'h028;
    // ==================== control a fields
    localparam int a_en_bit     = 7;
    localparam int a_res_bit    = 6;
    localparam int a_oe_bit     = 5;
    localparam int a_inv_bit    = 4;
    localparam int a_sp_bit     = 2;
    localparam int a_hys_bit    = 1;
    localparam int a_sync_bit   = 0;
    localparam logic [7:0] ctrl_a_rst  = 8'h04;
    localparam logic [7:0] ctrl_a_wmask = 8'hB7;
    // ==================== control b fields
    localparam int b_rise_bit   = 7;
    localparam int b_fall_bit   = 6;
    localparam int b_pos_lsb    = 4;
    localparam int b_neg_lsb    = 0;
    localparam logic [7:0] ctrl_b_rst  = 8'h00;
    localparam logic [7:0] ctrl_b_wmask = 8'hF3;
    // ==================== interrupt control fields
    localparam int ic_global_bit = 1;
    localparam int ic_group_bit  = 0;
    // ==================== positive input encodings
    localparam logic [1:0] pos_pin   = 2'h0;
    localparam logic [1:0] pos_dac   = 2'h1;
    localparam logic [1:0] pos_fixref = 2'h2;
    localparam logic [1:0] pos_gnd   = 2'h3;
endpackage

// ===== rtl/cmpc_chan.sv
// one comparator channel: routing, polarity, sync latch, edge flag
`timescale 1ns/1ps
module cmpc_chan (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] ctrl_a,
    input  wire logic [7:0] ctrl_b,
    input  wire logic       analog_result,
    input  wire logic       tmr_clk_fall,
    input  wire logic       flag_clear,
    output logic            result_q,
    output logic            sync_out_q,
    output logic            flag_q,
    output logic [3:0]      pos_sel_q,
    output logic [3:0]      neg_sel_q,
    output logic            hys_q,
    output logic            sp_q
);
    logic       enabled;
    logic       result_d;
    logic       rise;
    logic       fall;
    logic [3:0] pos_dec;
    logic [3:0] neg_dec;

    // ==================== polarity and routing
    assign enabled  = ctrl_a[cmpc_pkg::a_en_bit];
    // disabled analog reads low, so polarity still toggles the output
    assign result_d = (enabled & analog_result) ^ ctrl_a[cmpc_pkg::a_inv_bit];
    assign pos_dec  = 4'h1 << ctrl_b[cmpc_pkg::b_pos_lsb +: 2];
    assign neg_dec  = 4'h1 << ctrl_b[cmpc_pkg::b_neg_lsb +: 2];
    assign rise = result_d & ~result_q;
    assign fall = ~result_d & result_q;

    // ==================== registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q   <= 1'b0;
            sync_out_q <= 1'b0;
            flag_q     <= 1'b0;
            pos_sel_q  <= 4'h0;
            neg_sel_q  <= 4'h0;
            hys_q      <= 1'b0;
            sp_q       <= 1'b1;
        end else begin
            result_q  <= result_d;
            pos_sel_q <= enabled ? pos_dec : 4'h0;
            neg_sel_q <= enabled ? neg_dec : 4'h0;
            hys_q     <= ctrl_a[cmpc_pkg::a_hys_bit];
            sp_q      <= ctrl_a[cmpc_pkg::a_sp_bit];
            // falling timer edge latches; timer counts on rising, so no race
            if (!ctrl_a[cmpc_pkg::a_sync_bit] || tmr_clk_fall) begin
                sync_out_q <= result_d;
            end
            // set wins over a clear in the same cycle
            flag_q <= (rise & ctrl_b[cmpc_pkg::b_rise_bit])
                    | (fall & ctrl_b[cmpc_pkg::b_fall_bit])
                    | (flag_q & ~flag_clear);
        end
    end
endmodule // cmpc_chan

// ===== rtl/cmpc_top.sv
// comparator digital control top with apb register file
// ====================
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module cmpc_top #(
    parameter int N_CMP  = 2,
    parameter int N_PINS = 6
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [N_CMP-1:0]  analog_result,
    input  wire logic              tmr_src_clk,
    input  wire logic              tmr_presc_clk,
    input  wire logic              tmr_presc_on,
    input  wire logic [N_PINS-1:0] port_in,
    output logic      [N_CMP-1:0]  timer_gate_src,
    output logic      [N_CMP-1:0]  pwm_shutdown_src,
    output logic      [N_CMP-1:0]  out_pin,
    output logic      [N_CMP-1:0]  out_pin_oe,
    output logic      [N_CMP-1:0]  hysteresis_enable,
    output logic      [N_CMP-1:0]  speed_power_select,
    output logic      [4*N_CMP-1:0] positive_input_select,
    output logic      [4*N_CMP-1:0] negative_input_select,
    output logic                   irq
);
    // ==================== registers
    logic [7:0]        ctrl_a_q [N_CMP];
    logic [7:0]        ctrl_b_q [N_CMP];
    logic [N_CMP-1:0]  irq_en_q;
    logic [1:0]        irq_ctl_q;
    logic [N_PINS-1:0] analog_sel_q;
    logic [N_PINS-1:0] pindir_q;
    logic              tmr_clk_q;
    logic              pready_q;
    logic [31:0]       prdata_q;
    logic              pslverr_q;
    logic              irq_q;
    logic [N_CMP-1:0]  out_pin_q;
    logic [N_CMP-1:0]  out_oe_q;
    logic [N_CMP-1:0]  result;
    logic [N_CMP-1:0]  sync_out;
    logic [N_CMP-1:0]  flag;
    logic [N_CMP-1:0]  flag_clr;

    // ==================== bus decode
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic [31:0] rd_mux;
    logic        tmr_clk;
    logic        tmr_fall;
    assign wr_en = psel & penable & pwrite & ~pready_q;
    assign rd_en = psel & penable & ~pwrite & ~pready_q;
    // latch clock follows prescaler output when one is in use
    assign tmr_clk  = tmr_presc_on ? tmr_presc_clk : tmr_src_clk;
    assign tmr_fall = tmr_clk_q & ~tmr_clk;
    // write-one-to-clear on the flag register
    assign flag_clr = (wr_en && paddr == cmpc_pkg::irq_flag_off) ?
                      pwdata[N_CMP-1:0] : '0;

    always_comb begin
        rd_mux = 32'h0000_0000;
        hit    = 1'b1;
        case (paddr)
            cmpc_pkg::ctrl_a_off0: rd_mux[7:0] = {ctrl_a_q[0][7], result[0], ctrl_a_q[0][5:0]};
            cmpc_pkg::ctrl_b_off0: rd_mux[7:0] = ctrl_b_q[0];
            cmpc_pkg::ctrl_a_off1: rd_mux[7:0] = (N_CMP > 1) ?
                {ctrl_a_q[N_CMP-1][7], result[N_CMP-1], ctrl_a_q[N_CMP-1][5:0]} : 8'h00;
            cmpc_pkg::ctrl_b_off1: rd_mux[7:0] = (N_CMP > 1) ? ctrl_b_q[N_CMP-1] : 8'h00;
            cmpc_pkg::result_off:   rd_mux[N_CMP-1:0] = result;
            cmpc_pkg::irq_flag_off: rd_mux[N_CMP-1:0] = flag;
            cmpc_pkg::irq_en_off:   rd_mux[N_CMP-1:0] = irq_en_q;
            cmpc_pkg::irq_ctl_off:  rd_mux[1:0] = irq_ctl_q;
            cmpc_pkg::analog_sel_off: rd_mux[N_PINS-1:0] = analog_sel_q;
            cmpc_pkg::pindir_off:   rd_mux[N_PINS-1:0] = pindir_q;
            cmpc_pkg::port_off:     rd_mux[N_PINS-1:0] = port_in & ~analog_sel_q;
            default:                hit = 1'b0;
        endcase
    end

    // ==================== channels
    genvar g;
    generate
        for (g = 0; g < N_CMP; g++) begin : g_ch
            logic [11:0] a_off;
            logic [11:0] b_off;
            assign a_off = (g == 0) ? cmpc_pkg::ctrl_a_off0 : cmpc_pkg::ctrl_a_off1;
            assign b_off = (g == 0) ? cmpc_pkg::ctrl_b_off0 : cmpc_pkg::ctrl_b_off1;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl_a_q[g] <= cmpc_pkg::ctrl_a_rst;
                    ctrl_b_q[g] <= cmpc_pkg::ctrl_b_rst;
                end else begin
                    if (wr_en && paddr == a_off) begin
                        ctrl_a_q[g] <= pwdata[7:0] & cmpc_pkg::ctrl_a_wmask;
                    end
                    if (wr_en && paddr == b_off) begin
                        ctrl_b_q[g] <= pwdata[7:0] & cmpc_pkg::ctrl_b_wmask;
                    end
                end
            end
            cmpc_chan u_chan (
                .pclk          (pclk),
                .presetn       (presetn),
                .ctrl_a        (ctrl_a_q[g]),
                .ctrl_b        (ctrl_b_q[g]),
                .analog_result (analog_result[g]),
                .tmr_clk_fall  (tmr_fall),
                .flag_clear    (flag_clr[g]),
                .result_q      (result[g]),
                .sync_out_q    (sync_out[g]),
                .flag_q        (flag[g]),
                .pos_sel_q     (positive_input_select[4*g +: 4]),
                .neg_sel_q     (negative_input_select[4*g +: 4]),
                .hys_q         (hysteresis_enable[g]),
                .sp_q          (speed_power_select[g])
            );
            assign timer_gate_src[g]   = sync_out[g];
            assign pwm_shutdown_src[g] = result[g];
        end
    endgenerate

    // ==================== misc registers and apb answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q  <= '0;
            irq_ctl_q <= 2'h0;
            analog_sel_q <= '0;
            pindir_q  <= '0;
            tmr_clk_q <= 1'b0;
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            irq_q     <= 1'b0;
            out_pin_q <= '0;
            out_oe_q  <= '0;
        end else begin
            tmr_clk_q <= tmr_clk;
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~hit;
            prdata_q  <= rd_en ? rd_mux : 32'h0000_0000;
            if (wr_en && paddr == cmpc_pkg::irq_en_off)  irq_en_q  <= pwdata[N_CMP-1:0];
            if (wr_en && paddr == cmpc_pkg::irq_ctl_off) irq_ctl_q <= pwdata[1:0];
            if (wr_en && paddr == cmpc_pkg::analog_sel_off) analog_sel_q <= pwdata[N_PINS-1:0];
            if (wr_en && paddr == cmpc_pkg::pindir_off)  pindir_q  <= pwdata[N_PINS-1:0];
            irq_q <= (|(flag & irq_en_q)) & irq_ctl_q[cmpc_pkg::ic_group_bit]
                     & irq_ctl_q[cmpc_pkg::ic_global_bit];
            // comparator outputs assumed on pin indices 0..N_CMP-1
            for (int i = 0; i < N_CMP; i++) begin
                out_pin_q[i] <= sync_out[i];
                out_oe_q[i]  <= ctrl_a_q[i][cmpc_pkg::a_oe_bit] & ~pindir_q[i];
            end
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign irq        = irq_q;
    assign out_pin    = out_pin_q;
    assign out_pin_oe = out_oe_q;
endmodule // cmpc_top

// ===== sim/cmpc_assertions.sv
// concurrent checks on the comparator control block ports
`timescale 1ns/1ps
module cmpc_assertions #(
    parameter int N_CMP = 2
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [31:0]        prdata,
    input wire logic [N_CMP-1:0]   timer_gate_src,
    input wire logic [N_CMP-1:0]   out_pin,
    input wire logic [N_CMP-1:0]   speed_power_select,
    input wire logic [4*N_CMP-1:0] positive_input_select,
    input wire logic [4*N_CMP-1:0] negative_input_select
);
    // ====================
    // apb handshake and register defaults
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_access_ready: assert property (psel && penable && !pready |=> pready)
        else $error("no pready one cycle after access start");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("prdata not zero outside answer");
    chk_sp_reset: assert property ($rose(presetn) |-> speed_power_select == '1)
        else $error("speed select not fast after reset");
    // ====================
    // input routing and output pin
    chk_sel_onehot: assert property ($onehot0(positive_input_select[3:0])
        && $onehot0(negative_input_select[3:0])) else $error("input select not one-hot");
    chk_off_both: assert property ((positive_input_select[3:0] == '0)
        == (negative_input_select[3:0] == '0)) else $error("inputs not disconnected together");
    chk_pin_follow: assert property (out_pin == $past(timer_gate_src))
        else $error("pin does not follow timer output");
endmodule // cmpc_assertions

// ===== sim/cmpc_timer_model.sv
// behavioural timer model fed by the comparator output gate
`timescale 1ns/1ps
module cmpc_timer_model (
    input wire logic pclk,
    input wire logic run_src,
    input wire logic run_presc,
    input wire logic gate,
    output logic     src_clk,
    output logic     presc_clk,
    output logic [15:0] count
);
    logic [3:0] div_q = 4'h0;
    logic       presc_q = 1'b0;
    // clocks stand still while not running
    always @(posedge pclk) if (run_src) div_q <= div_q + 4'h1;
    always @(posedge pclk) if (run_presc) presc_q <= div_q[3];
    assign src_clk = div_q[1];
    assign presc_clk = presc_q;
    // counts on rising edge, comparator latches on falling
    initial count = 16'h0000;
    always @(posedge src_clk) if (gate) count <= count + 16'h0001;
endmodule // cmpc_timer_model

// ===== sim/testbench.sv
// top testbench: apb register tests of the comparator control block
`timescale 1ns/1ps
module testbench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, tsc, tpc, irq, err, presc_on = 0, run_s = 0, run_p = 0;
    logic [1:0]  ares = '0, tgs, pws, opin, ooe, hys, spd;
    logic [5:0]  port_in = 6'h3F;
    logic [7:0]  psl, nsl;
    logic [15:0] cnt, cnt0;
    int          n_fail = 0, n_tests = 0, cyc = 0;
    always #20 pclk = ~pclk;
    cmpc_top #(.N_CMP(2), .N_PINS(6)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .analog_result(ares), .tmr_src_clk(tsc),
        .tmr_presc_clk(tpc), .tmr_presc_on(presc_on), .port_in(port_in), .timer_gate_src(tgs),
        .pwm_shutdown_src(pws), .out_pin(opin), .out_pin_oe(ooe), .hysteresis_enable(hys),
        .speed_power_select(spd), .positive_input_select(psl), .negative_input_select(nsl),
        .irq(irq));
    cmpc_timer_model i_tmr (.pclk(pclk), .run_src(run_s), .run_presc(run_p), .gate(tgs[0]),
        .src_clk(tsc), .presc_clk(tpc), .count(cnt));
    // ====================
    // tasks
    task automatic test_done;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // entered just after a rising edge; settles outputs before returning
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done;
        end
    end
    // ====================
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rdc(cmpc_pkg::ctrl_a_off0, 32'h0000_0004);
        rdc(cmpc_pkg::ctrl_a_off1, 32'h0000_0004);
        chk(32'(spd), 32'h0000_0003);
        rdc(12'h0FC, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        apb(1, cmpc_pkg::ctrl_a_off0, 32'h0000_0081);
        ares <= 2'b01;
        repeat (6) @(posedge pclk);
        chk(32'(pws), 32'h0000_0001);
        chk(32'(tgs), 32'h0000_0000);
        rdc(cmpc_pkg::result_off, 32'h0000_0001);
        run_s <= 1;
        repeat (20) @(posedge pclk);
        chk(32'(tgs), 32'h0000_0001);
        presc_on <= 1;
        // switching the latch clock may look like one fall; let it pass first
        @(posedge pclk);
        ares <= 2'b00;
        repeat (20) @(posedge pclk);
        chk(32'(tgs), 32'h0000_0001);
        run_p <= 1;
        repeat (40) @(posedge pclk);
        chk(32'(tgs), 32'h0000_0000);
        cnt0 = cnt;
        repeat (8) @(posedge pclk);
        chk(32'(cnt), 32'(cnt0));
        chk(32'(cnt0 != 16'h0000), 32'h0000_0001);
        apb(1, cmpc_pkg::ctrl_a_off0, 32'h0000_0080);
        apb(1, cmpc_pkg::irq_flag_off, 32'h0000_0003);
        apb(1, cmpc_pkg::ctrl_b_off0, 32'h0000_0080);
        apb(1, cmpc_pkg::ctrl_a_off0, 32'h0000_0010);
        rdc(cmpc_pkg::irq_flag_off, 32'h0000_0001);
        rdc(cmpc_pkg::ctrl_a_off0, 32'h0000_0050);
        apb(1, cmpc_pkg::irq_flag_off, 32'h0000_0001);
        rdc(cmpc_pkg::irq_flag_off, 32'h0000_0000);
        apb(1, cmpc_pkg::ctrl_a_off0, 32'h0000_0000);
        rdc(cmpc_pkg::irq_flag_off, 32'h0000_0000);
        apb(1, cmpc_pkg::ctrl_a_off0, 32'h0000_0010);
        apb(1, cmpc_pkg::irq_en_off, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            apb(1, cmpc_pkg::irq_ctl_off, 32'(i));
            chk(32'(irq), 32'(i == 3));
        end
        apb(1, cmpc_pkg::pindir_off, 32'h0000_0000);
        apb(1, cmpc_pkg::ctrl_a_off0, 32'h0000_0030);
        chk(32'({ooe[0], opin[0]}), 32'h0000_0003);
        apb(1, cmpc_pkg::pindir_off, 32'h0000_003F);
        chk(32'(ooe[0]), 32'h0000_0000);
        for (int v = 0; v < 4; v++) begin
            apb(1, cmpc_pkg::ctrl_b_off0, 32'(v * 17));
            apb(1, cmpc_pkg::ctrl_a_off0, 32'h0000_0080);
            chk(32'({psl[3:0], nsl[3:0]}), 32'(17 << v));
        end
        apb(1, cmpc_pkg::ctrl_a_off0, 32'h0000_0000);
        chk(32'({psl[3:0], nsl[3:0]}), 32'h0000_0000);
        apb(1, cmpc_pkg::ctrl_a_off0, 32'h0000_0002);
        chk(32'({spd[0], hys[0]}), 32'h0000_0001);
        rdc(cmpc_pkg::ctrl_a_off0, 32'h0000_0002);
        apb(1, cmpc_pkg::ctrl_a_off0, 32'h0000_0004);
        chk(32'({spd[0], hys[0]}), 32'h0000_0002);
        apb(1, cmpc_pkg::analog_sel_off, 32'h0000_0005);
        rdc(cmpc_pkg::port_off, 32'h0000_003A);
        test_done;
    end
endmodule // testbench
bind cmpc_top cmpc_assertions #(.N_CMP(N_CMP)) i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .timer_gate_src(timer_gate_src), .out_pin(out_pin), .speed_power_select(speed_power_select),
    .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select));
